/* logic/ufc_regs.sv */
// ufc_regs: function control and interface control registers of the
// transceiver, reached through the register access port of the link bus.
// assumes the link bus front end decodes register reads and writes into
// one-cycle strobes with a 6-bit address, all synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ufc_regs (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// register access port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// link bus events
	input wire logic stp,
	output logic dir,
	output logic rxcmd_update,
	// wake and serial mode events from the transceiver
	input wire logic three_wire_exit,
	input wire logic six_wire_exit,
	// pull-down controls held elsewhere
	input wire logic plus_line_pulldown,
	input wire logic minus_line_pulldown,
	// power and core control
	output logic low_power,
	output logic core_rst,
	// transmit and line controls
	output logic [1:0] tx_encoding_style,
	output logic tx_non_driving,
	output logic tx_no_stuff_nrzi,
	output logic tx_no_sync_eop,
	output logic [1:0] line_speed_choice,
	output logic ls_via_fs_preamble,
	output logic termination_choice,
	output logic fs_pullup_en,
	output logic hs_term_en,
	// alternative interface controls
	output logic bus_guard_disable,
	output logic indicator_bypass,
	output logic indicator_invert,
	output logic serial_clock_keep_n,
	output logic three_wire_serial_mode,
	output logic six_wire_serial_mode
);
	logic [7:0] func_reg;
	logic [7:0] intf_reg;
	ufc_pkg::ufc_op_e func_op;
	ufc_pkg::ufc_op_e intf_op;
	logic [7:0] next_func;
	logic [7:0] next_intf;
	logic seq_start;
	logic seq_dir;
	logic seq_core_rst;
	logic seq_done;

	// write kind for one register from its three addresses
	function automatic ufc_pkg::ufc_op_e decode_op(input logic wr,
			input logic [5:0] addr, input logic [5:0] base);
		if (!wr)
			decode_op = ufc_pkg::ufc_op_none;
		else if (addr == base)
			decode_op = ufc_pkg::ufc_op_write;
		else if (addr == 6'(base + 6'h01))
			decode_op = ufc_pkg::ufc_op_set;
		else if (addr == 6'(base + 6'h02))
			decode_op = ufc_pkg::ufc_op_clear;
		else
			decode_op = ufc_pkg::ufc_op_none;
	endfunction : decode_op

	function automatic logic [7:0] apply_op(input ufc_pkg::ufc_op_e op,
			input logic [7:0] cur, input logic [7:0] data);
		case (op)
			ufc_pkg::ufc_op_write: apply_op = data;
			ufc_pkg::ufc_op_set: apply_op = cur | data;
			ufc_pkg::ufc_op_clear: apply_op = cur & ~data;
			default: apply_op = cur;
		endcase
	endfunction : apply_op

	function automatic logic in_window(input logic [5:0] addr,
			input logic [5:0] base);
		in_window = (addr >= base) && (addr <= 6'(base + 6'h02));
	endfunction : in_window

	always_comb begin
		func_op = decode_op(reg_wr, reg_addr, ufc_pkg::FUNC_WR_ADDR);
		intf_op = decode_op(reg_wr, reg_addr, ufc_pkg::INTF_WR_ADDR);
		next_func = apply_op(func_op, func_reg, reg_wdata);
		next_intf = apply_op(intf_op, intf_reg, reg_wdata);
		next_func[ufc_pkg::FUNC_RSVD_BIT] = 1'b0;
		// a fresh 0->1 of the reset bit launches one core reset
		seq_start = next_func[ufc_pkg::FUNC_CORE_RESET_BIT] &
			~func_reg[ufc_pkg::FUNC_CORE_RESET_BIT];
	end

	ufc_core_reset_seq u_seq (
		.clk_sys(clk_sys),
		.srst(srst),
		.start(seq_start),
		.dir_hold(seq_dir),
		.core_rst(seq_core_rst),
		.done(seq_done)
	);

	// function control register with its self-updating bits
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			func_reg <= ufc_pkg::FUNC_RESET_VALUE;
		end else begin
			func_reg <= next_func;
			// the link keeps off the bus during core reset, so completion
			// and a write never meet; the write would still win if they did
			if (seq_done && func_op == ufc_pkg::ufc_op_none)
				func_reg[ufc_pkg::FUNC_CORE_RESET_BIT] <= 1'b0;
			// stop during low power wakes the transceiver
			if (stp && !func_reg[ufc_pkg::FUNC_LOW_POWER_N_BIT])
				func_reg[ufc_pkg::FUNC_LOW_POWER_N_BIT] <= 1'b1;
		end
	end

	// interface control register; mode exclusivity is left to the link
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			intf_reg <= ufc_pkg::INTF_RESET_VALUE;
		end else begin
			intf_reg <= next_intf;
			if (three_wire_exit && intf_op == ufc_pkg::ufc_op_none)
				intf_reg[ufc_pkg::INTF_THREE_WIRE_BIT] <= 1'b0;
			if (six_wire_exit && intf_op == ufc_pkg::ufc_op_none)
				intf_reg[ufc_pkg::INTF_SIX_WIRE_BIT] <= 1'b0;
		end
	end

	// read port: one cycle after the strobe, unmapped reads give zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (!reg_rd)
				reg_rdata <= reg_rdata;
			else if (in_window(reg_addr, ufc_pkg::FUNC_WR_ADDR))
				reg_rdata <= func_reg;
			else if (in_window(reg_addr, ufc_pkg::INTF_WR_ADDR))
				reg_rdata <= intf_reg;
			else
				reg_rdata <= 8'h00;
		end
	end

	// link bus turnaround and core reset
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dir <= 1'b0;
			core_rst <= 1'b0;
			rxcmd_update <= 1'b0;
		end else begin
			dir <= seq_dir;
			core_rst <= seq_core_rst;
			// status request rises as direction drops; the status itself
			// goes out only after the turnaround cycle
			rxcmd_update <= seq_done;
		end
	end

	// decoded controls, registered so every output is a flip-flop
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			low_power <= 1'b0;
			tx_encoding_style <= ufc_pkg::ENC_NORMAL;
			tx_non_driving <= 1'b0;
			tx_no_stuff_nrzi <= 1'b0;
			tx_no_sync_eop <= 1'b0;
			line_speed_choice <= ufc_pkg::SPEED_FULL;
			ls_via_fs_preamble <= 1'b0;
			termination_choice <= 1'b0;
			fs_pullup_en <= 1'b0;
			hs_term_en <= 1'b0;
		end else begin
			low_power <= ~func_reg[ufc_pkg::FUNC_LOW_POWER_N_BIT];
			tx_encoding_style <= func_reg[ufc_pkg::FUNC_ENC_HI_BIT:
				ufc_pkg::FUNC_ENC_LO_BIT];
			tx_non_driving <= func_reg[ufc_pkg::FUNC_ENC_HI_BIT:
				ufc_pkg::FUNC_ENC_LO_BIT] == ufc_pkg::ENC_NON_DRIVING;
			tx_no_stuff_nrzi <= func_reg[ufc_pkg::FUNC_ENC_HI_BIT:
				ufc_pkg::FUNC_ENC_LO_BIT] == ufc_pkg::ENC_NO_STUFF_NRZI;
			tx_no_sync_eop <= func_reg[ufc_pkg::FUNC_ENC_HI_BIT:
				ufc_pkg::FUNC_ENC_LO_BIT] == ufc_pkg::ENC_NO_SYNC_EOP;
			line_speed_choice <= func_reg[ufc_pkg::FUNC_SPEED_HI_BIT:
				ufc_pkg::FUNC_SPEED_LO_BIT];
			ls_via_fs_preamble <= func_reg[ufc_pkg::FUNC_SPEED_HI_BIT:
				ufc_pkg::FUNC_SPEED_LO_BIT] == ufc_pkg::SPEED_LOW_VIA_FULL;
			termination_choice <= func_reg[ufc_pkg::FUNC_TERM_BIT];
			// pull-up never fights a pull-down on the same line, and a
			// non-driving transmitter leaves the high-speed termination to the link
			fs_pullup_en <= func_reg[ufc_pkg::FUNC_TERM_BIT] &
				~plus_line_pulldown & ~minus_line_pulldown &
				(func_reg[ufc_pkg::FUNC_SPEED_HI_BIT:
				ufc_pkg::FUNC_SPEED_LO_BIT] != ufc_pkg::SPEED_HIGH);
			hs_term_en <= ~func_reg[ufc_pkg::FUNC_TERM_BIT] &
				(func_reg[ufc_pkg::FUNC_SPEED_HI_BIT:
				ufc_pkg::FUNC_SPEED_LO_BIT] == ufc_pkg::SPEED_HIGH) &
				(func_reg[ufc_pkg::FUNC_ENC_HI_BIT:
				ufc_pkg::FUNC_ENC_LO_BIT] != ufc_pkg::ENC_NON_DRIVING);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bus_guard_disable <= 1'b0;
			indicator_bypass <= 1'b0;
			indicator_invert <= 1'b0;
			serial_clock_keep_n <= 1'b0;
			three_wire_serial_mode <= 1'b0;
			six_wire_serial_mode <= 1'b0;
		end else begin
			bus_guard_disable <= intf_reg[ufc_pkg::INTF_GUARD_DIS_BIT];
			indicator_bypass <= intf_reg[ufc_pkg::INTF_IND_BYPASS_BIT];
			indicator_invert <= intf_reg[ufc_pkg::INTF_IND_INVERT_BIT];
			serial_clock_keep_n <= intf_reg[ufc_pkg::INTF_CLK_KEEP_N_BIT];
			three_wire_serial_mode <= intf_reg[ufc_pkg::INTF_THREE_WIRE_BIT];
			six_wire_serial_mode <= intf_reg[ufc_pkg::INTF_SIX_WIRE_BIT];
		end
	end
endmodule : ufc_regs
`default_nettype wire

/* logic/ufc_pkg.sv */
// ufc_pkg: addresses, field positions, reset values and timing of the
// function control and interface control register pair.
// assumes a single 10 MHz system clock shared by every user of the package.
package ufc_pkg;
	// register addresses on the 6-bit register access port
	localparam logic [5:0] FUNC_WR_ADDR = 6'h04;
	localparam logic [5:0] FUNC_SET_ADDR = 6'h05;
	localparam logic [5:0] FUNC_CLR_ADDR = 6'h06;
	localparam logic [5:0] INTF_WR_ADDR = 6'h07;
	localparam logic [5:0] INTF_SET_ADDR = 6'h08;
	localparam logic [5:0] INTF_CLR_ADDR = 6'h09;

	// function control fields
	localparam int FUNC_RSVD_BIT = 7;
	localparam int FUNC_LOW_POWER_N_BIT = 6;
	localparam int FUNC_CORE_RESET_BIT = 5;
	localparam int FUNC_ENC_HI_BIT = 4;
	localparam int FUNC_ENC_LO_BIT = 3;
	localparam int FUNC_TERM_BIT = 2;
	localparam int FUNC_SPEED_HI_BIT = 1;
	localparam int FUNC_SPEED_LO_BIT = 0;
	localparam logic [7:0] FUNC_RESET_VALUE = 8'h41;

	// interface control fields
	localparam int INTF_GUARD_DIS_BIT = 7;
	localparam int INTF_IND_BYPASS_BIT = 6;
	localparam int INTF_IND_INVERT_BIT = 5;
	localparam int INTF_CLK_KEEP_N_BIT = 3;
	localparam int INTF_THREE_WIRE_BIT = 1;
	localparam int INTF_SIX_WIRE_BIT = 0;
	localparam logic [7:0] INTF_RESET_VALUE = 8'h00;

	// transmit encoding styles
	localparam logic [1:0] ENC_NORMAL = 2'h0;
	localparam logic [1:0] ENC_NON_DRIVING = 2'h1;
	localparam logic [1:0] ENC_NO_STUFF_NRZI = 2'h2;
	localparam logic [1:0] ENC_NO_SYNC_EOP = 2'h3;

	// line speed choices
	localparam logic [1:0] SPEED_HIGH = 2'h0;
	localparam logic [1:0] SPEED_FULL = 2'h1;
	localparam logic [1:0] SPEED_LOW = 2'h2;
	localparam logic [1:0] SPEED_LOW_VIA_FULL = 2'h3;

	// core reset duration
	localparam int CLK_PERIOD_NS = 100;
	localparam int CORE_RESET_NS = 1000;
	localparam int CORE_RESET_CYCLES =
		(CORE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CORE_RESET_COUNT = 8'(CORE_RESET_CYCLES);

	// register write kinds
	typedef enum logic [1:0] {
		ufc_op_none,
		ufc_op_write,
		ufc_op_set,
		ufc_op_clear
	} ufc_op_e;
endpackage : ufc_pkg

/* logic/ufc_core_reset_seq.sv */
// ufc_core_reset_seq: drives the bus turnaround and core reset while a
// requested core reset runs, then signals completion.
// assumes start is a one-cycle pulse and is not repeated while busy.
`timescale 1ns/1ps
`default_nettype none
module ufc_core_reset_seq (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// request
	input wire logic start,
	// status
	output logic dir_hold,
	output logic core_rst,
	output logic done
);
	typedef enum logic [1:0] {ufc_seq_idle, ufc_seq_run, ufc_seq_end} ufc_seq_e;
	ufc_seq_e state;
	logic [7:0] count;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= ufc_seq_idle;
			count <= 8'h00;
			dir_hold <= 1'b0;
			core_rst <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				ufc_seq_idle: begin
					if (start) begin
						state <= ufc_seq_run;
						count <= ufc_pkg::CORE_RESET_COUNT;
						dir_hold <= 1'b1;
						core_rst <= 1'b1;
					end
				end
				ufc_seq_run: begin
					if (count == 8'h01) begin
						state <= ufc_seq_end;
						core_rst <= 1'b0;
					end
					count <= count - 8'h01;
				end
				ufc_seq_end: begin
					// bus is handed back on the same edge as the completion
					// pulse, so the status request sees direction already low
					state <= ufc_seq_idle;
					dir_hold <= 1'b0;
					done <= 1'b1;
				end
				default: begin
					state <= ufc_seq_idle;
				end
			endcase
		end
	end
endmodule : ufc_core_reset_seq
`default_nettype wire

/* bench/ufc_regs_chk_sva.sv */
// ufc_regs_chk: port-level timing checks of the control register pair.
// assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ufc_regs_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// link and core events
	input wire logic stp,
	input wire logic dir,
	input wire logic rxcmd_update,
	input wire logic three_wire_exit,
	input wire logic low_power,
	input wire logic core_rst,
	// decoded controls
	input wire logic [1:0] tx_encoding_style,
	input wire logic tx_no_sync_eop,
	input wire logic [1:0] line_speed_choice,
	input wire logic ls_via_fs_preamble,
	input wire logic three_wire_serial_mode
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	property p_rd_unmapped;
		reg_rd && (reg_addr < 6'h04 || reg_addr > 6'h09) |=> reg_rdata == 8'h00;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("unmapped read not zero");
	property p_rst_dir;
		$rose(core_rst) |-> dir;
	endproperty
	a_rst_dir: assert property (p_rst_dir)
		else $error("core reset without bus direction");
	property p_rst_len;
		$rose(core_rst) |-> core_rst [*8] ##1 core_rst [*2] ##1 !core_rst;
	endproperty
	a_rst_len: assert property (p_rst_len)
		else $error("core reset length wrong");
	property p_dir_drop;
		$fell(core_rst) |-> dir ##1 !dir;
	endproperty
	a_dir_drop: assert property (p_dir_drop)
		else $error("direction not dropped after core reset");
	property p_rxcmd;
		$fell(dir) |-> ##[0:1] rxcmd_update;
	endproperty
	a_rxcmd: assert property (p_rxcmd)
		else $error("no status update after core reset");
	property p_wake;
		stp && low_power |-> ##[1:2] !low_power;
	endproperty
	a_wake: assert property (p_wake)
		else $error("stop did not end low power");
	property p_enc;
		tx_no_sync_eop == (tx_encoding_style == ufc_pkg::ENC_NO_SYNC_EOP);
	endproperty
	a_enc: assert property (p_enc)
		else $error("sync and eop decode wrong");
	property p_preamble;
		ls_via_fs_preamble ==
			(line_speed_choice == ufc_pkg::SPEED_LOW_VIA_FULL);
	endproperty
	a_preamble: assert property (p_preamble)
		else $error("preamble decode wrong");
	property p_serial_exit;
		three_wire_exit && !reg_wr |-> ##2 !three_wire_serial_mode;
	endproperty
	a_serial_exit: assert property (p_serial_exit)
		else $error("serial mode not cleared on exit");
	property p_func_wr;
		reg_wr && reg_addr == ufc_pkg::FUNC_WR_ADDR ##1 !reg_wr |=>
			line_speed_choice == 2'($past(reg_wdata, 2)) &&
			tx_encoding_style == 2'($past(reg_wdata, 2) >> 3);
	endproperty
	a_func_wr: assert property (p_func_wr)
		else $error("function write not applied");
	c_core_rst: cover property ($rose(core_rst));
	c_wake: cover property (stp && low_power);
	c_exit: cover property (three_wire_exit && three_wire_serial_mode);
endmodule : ufc_regs_chk
bind ufc_regs ufc_regs_chk i_chk (.clk_sys, .srst, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .stp, .dir, .rxcmd_update,
	.three_wire_exit, .low_power, .core_rst, .tx_encoding_style,
	.tx_no_sync_eop, .line_speed_choice, .ls_via_fs_preamble,
	.three_wire_serial_mode);
`default_nettype wire

/* bench/ufc_link_model.sv */
// ufc_link_model: link controller side of the register port and stop line.
// assumes it alone drives the strobes, address, data and stop.
`timescale 1ns/1ps
`default_nettype none
module ufc_link_model (
	// clock and answers
	input wire logic clk_sys,
	input wire logic dir,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// requests
	output logic reg_wr,
	output logic reg_rd,
	output logic [5:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic stp
);
	int n;
	int n_stuck = 0;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		stp = 1'b0;
	end
	// bounded so a stuck direction cannot hang the link
	task automatic wait_bus();
		n = 0;
		while (dir !== 1'b0 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		// a direction that never drops is counted, not hidden
		if (dir !== 1'b0)
			n_stuck++;
	endtask : wait_bus
	task automatic write(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wait_bus();
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		// released data does not keep its old value
		reg_wdata <= ~d;
	endtask : write
	task automatic read(input logic [5:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk_sys);
		wait_bus();
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		v = reg_rvalid;
		d = reg_rdata;
	endtask : read
	task automatic wake();
		@(posedge clk_sys);
		stp <= 1'b1;
		@(posedge clk_sys);
		stp <= 1'b0;
	endtask : wake
endmodule : ufc_link_model
`default_nettype wire

/* bench/ufc_regs_bench.sv */
// ufc_regs_bench: register sequences with expected values for ufc_regs.
// assumes the link model drives the register port; 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module ufc_regs_bench;
	logic clk_sys, srst, three_wire_exit, six_wire_exit;
	logic plus_line_pulldown, minus_line_pulldown, reg_wr, reg_rd, stp;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic reg_rvalid, dir, rxcmd_update, low_power, core_rst, seen;
	logic [1:0] tx_encoding_style, line_speed_choice;
	logic tx_non_driving, tx_no_stuff_nrzi, tx_no_sync_eop;
	logic ls_via_fs_preamble, termination_choice, fs_pullup_en;
	logic hs_term_en, bus_guard_disable, three_wire_serial_mode;
	logic six_wire_serial_mode, indicator_bypass, indicator_invert;
	logic serial_clock_keep_n;
	int bad_count = 0;
	int n_compared = 0;
	int n;
	int fld_pos[4] = '{ufc_pkg::INTF_GUARD_DIS_BIT,
		ufc_pkg::INTF_IND_BYPASS_BIT, ufc_pkg::INTF_IND_INVERT_BIT,
		ufc_pkg::INTF_CLK_KEEP_N_BIT};
	ufc_regs i_dut (.clk_sys, .srst, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_rvalid, .stp, .dir, .rxcmd_update,
		.three_wire_exit, .six_wire_exit, .plus_line_pulldown,
		.minus_line_pulldown, .low_power, .core_rst, .tx_encoding_style,
		.tx_non_driving, .tx_no_stuff_nrzi, .tx_no_sync_eop,
		.line_speed_choice, .ls_via_fs_preamble, .termination_choice,
		.fs_pullup_en, .hs_term_en, .bus_guard_disable,
		.indicator_bypass, .indicator_invert, .serial_clock_keep_n,
		.three_wire_serial_mode, .six_wire_serial_mode);
	ufc_link_model i_link (.clk_sys, .dir, .reg_rdata, .reg_rvalid,
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .stp);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		i_link.read(a, d, v);
		check("read valid", 8'h01, {7'h00, v});
		check("read data", exp, d);
	endtask : rd
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	initial begin
		#(100 * 4000);
		bad_count++;
		test_done();
	end
	initial begin
		srst = 1'b1;
		three_wire_exit = 1'b0;
		six_wire_exit = 1'b0;
		plus_line_pulldown = 1'b0;
		minus_line_pulldown = 1'b0;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		for (int a = 4; a < 10; a++) begin
			rd(6'(a), (a < 7) ? ufc_pkg::FUNC_RESET_VALUE :
				ufc_pkg::INTF_RESET_VALUE);
		end
		i_link.write(ufc_pkg::FUNC_WR_ADDR, 8'h98);
		repeat (2) @(posedge clk_sys);
		check("low power", 8'h03, {6'h00, low_power, hs_term_en});
		rd(ufc_pkg::FUNC_SET_ADDR, 8'h18);
		i_link.write(ufc_pkg::FUNC_CLR_ADDR, 8'h10);
		i_link.write(ufc_pkg::FUNC_SET_ADDR, 8'h05);
		repeat (2) @(posedge clk_sys);
		check("pullup", 8'h03, {6'h00, fs_pullup_en, termination_choice});
		minus_line_pulldown <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check("pullup off", 8'h00, {7'h00, fs_pullup_en});
		minus_line_pulldown <= 1'b0;
		rd(ufc_pkg::FUNC_CLR_ADDR, 8'h0d);
		i_link.wake();
		repeat (2) @(posedge clk_sys);
		check("awake", 8'h00, {7'h00, low_power});
		rd(ufc_pkg::FUNC_WR_ADDR, 8'h4d);
		// high speed is paired with the no-sync style, as the link must
		for (int i = 0; i < 4; i++) begin
			i_link.write(ufc_pkg::FUNC_WR_ADDR, 8'(8'h40 | (i << 3) | (3 - i)));
			repeat (2) @(posedge clk_sys);
			check("style", {4'h0, 2'(i), 2'(3 - i)},
				{4'h0, tx_encoding_style, line_speed_choice});
			check("decode", {4'h0, i == 0, i == 3, i == 2, i == 1},
				{4'h0, ls_via_fs_preamble, tx_no_sync_eop, tx_no_stuff_nrzi,
				tx_non_driving});
		end
		i_link.write(ufc_pkg::FUNC_SET_ADDR, 8'h20);
		n = 0;
		seen = 1'b0;
		for (int c = 0; c < 40; c++) begin
			@(posedge clk_sys);
			n += (core_rst === 1'b1 && dir === 1'b1);
			seen |= (rxcmd_update === 1'b1);
		end
		check("reset span", 8'(ufc_pkg::CORE_RESET_CYCLES), 8'(n));
		check("update and dir", 8'h01, {6'h00, dir, seen});
		rd(ufc_pkg::FUNC_WR_ADDR, 8'h58);
		for (int j = 0; j < 2; j++) begin
			i_link.write(ufc_pkg::INTF_SET_ADDR, 8'(1 << j));
			repeat (2) @(posedge clk_sys);
			check("serial", 8'(1 << j), {6'h00, three_wire_serial_mode,
				six_wire_serial_mode});
			six_wire_exit <= (j == 0);
			three_wire_exit <= (j == 1);
			@(posedge clk_sys);
			six_wire_exit <= 1'b0;
			three_wire_exit <= 1'b0;
			rd(ufc_pkg::INTF_WR_ADDR, 8'h00);
		end
		// one field at a time, so the link never mixes interface modes
		for (int b = 0; b < 4; b++) begin
			i_link.write(ufc_pkg::INTF_WR_ADDR, 8'(1 << fld_pos[b]));
			repeat (2) @(posedge clk_sys);
			check("intf field", 8'(8 >> b), {4'h0, bus_guard_disable,
				indicator_bypass, indicator_invert,
				serial_clock_keep_n});
		end
		i_link.write(ufc_pkg::INTF_WR_ADDR, 8'h94);
		repeat (2) @(posedge clk_sys);
		check("guard", 8'h01, {7'h00, bus_guard_disable});
		i_link.write(ufc_pkg::INTF_CLR_ADDR, 8'h84);
		i_link.write(6'h0a, 8'hff);
		rd(6'h0a, 8'h00);
		rd(ufc_pkg::INTF_SET_ADDR, 8'h10);
		check("bus waits", 8'h00, 8'(i_link.n_stuck));
		test_done();
	end
endmodule : ufc_regs_bench
`default_nettype wire
